// *** adc_cfg_defines.vh ***
`ifndef ADC_CFG_DEFINES_VH
`define ADC_CFG_DEFINES_VH

// ----------------------------------------------------------------
// Register addresses on the serial control port
// ----------------------------------------------------------------
`define ADDR_CODING_TEST 5'h00
`define ADDR_CLK_BUF 5'h04
`define ADDR_USER_LOW 5'h0b
`define ADDR_STEP_GAIN 5'h0c
`define ADDR_FRAMING 5'h0d

// ----------------------------------------------------------------
// Reset value and serial word layout
// ----------------------------------------------------------------
`define CFG_RESET 11'h000
`define SER_WORD_BITS 5'h10
`define SOFT_RESET_BIT 10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CODING_BIT 9
`define TEST_HI 7
`define TEST_LO 5
`define CLKBUF_HI 6
`define CLKBUF_LO 2
`define STEP_GAIN_HI 10
`define STEP_GAIN_LO 8
`define USER_TOP_BIT 0
`define FR_TWO_LANE 0
`define FR_SDR 1
`define FR_14X 2
`define FR_RISE_EDGE 4
`define FR_BOOST 5
`define FR_LSB_FIRST 6
`define FR_BIT_WISE 7
`define FR_OVERRIDE 10

// ----------------------------------------------------------------
// Output test selection codes
// ----------------------------------------------------------------
`define TEST_NORMAL 3'h0
`define TEST_ZEROS 3'h1
`define TEST_ONES 3'h2
`define TEST_TOGGLE 3'h3
`define TEST_UNUSED 3'h4
`define TEST_USER 3'h5
`define TEST_DESKEW 3'h6
`define TEST_SYNC 3'h7

// ----------------------------------------------------------------
// Pattern words
// ----------------------------------------------------------------
`define WORD_ZEROS 12'h000
`define WORD_ONES 12'hfff
`define WORD_TOGGLE_A 12'haaa
`define WORD_TOGGLE_B 12'h555
`define WORD_DESKEW 12'haaa
`define WORD_SYNC 12'hfc0

// ----------------------------------------------------------------
// Sample clock buffer gain codes
// ----------------------------------------------------------------
`define CLKBUF_MIN 5'h18
`define CLKBUF_DEF 5'h00
`define CLKBUF_G2 5'h0c
`define CLKBUF_G3 5'h0a
`define CLKBUF_G4 5'h09
`define CLKBUF_MAX 5'h08

`endif

// *** ser_word_receiver.v ***
`timescale 1ns/100ps
`include "adc_cfg_defines.vh"

// Collects 16-bit words from the serial control port, address first.
module ser_word_receiver (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Serial control pins
    input wire sen_n,
    input wire sclk,
    input wire sdata,
    // Received word
    output reg [4:0] addr_q,
    output reg [10:0] data_q,
    output reg strobe_q
);

reg sclk_q;
reg [15:0] shift_q;
reg [4:0] count_q;
wire fall;

// Data is taken on the falling edge of the serial clock.
assign fall = sclk_q & ~sclk;

// Shift in bits while enabled; a word completes on its sixteenth bit.
always @(posedge clk) begin
    if (!rst_n) begin
        sclk_q <= 1'b0;
        shift_q <= 16'h0000;
        count_q <= 5'h00;
        addr_q <= 5'h00;
        data_q <= 11'h000;
        strobe_q <= 1'b0;
    end else begin
        sclk_q <= sclk;
        strobe_q <= 1'b0;
        if (sen_n) begin
            count_q <= 5'h00;
        end else if (fall) begin
            shift_q <= {shift_q[14:0], sdata};
            if (count_q == `SER_WORD_BITS - 5'h01) begin
                addr_q <= shift_q[14:10];
                data_q <= {shift_q[9:0], sdata};
                strobe_q <= 1'b1;
                count_q <= 5'h00;
            end else begin
                count_q <= count_q + 5'h01;
            end
        end
    end
end

endmodule // ser_word_receiver

// *** word_pattern_gen.v ***
`timescale 1ns/100ps
`include "adc_cfg_defines.vh"

// Builds one channel's transmit word from results or a test pattern.
module word_pattern_gen (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Sample in
    input wire sample_valid,
    input wire [11:0] sample,
    // Settings
    input wire [2:0] test_sel,
    input wire straight_bin,
    input wire [11:0] user_word,
    input wire toggle_phase,
    input wire lsb_first,
    input wire two_lane,
    input wire bit_wise,
    // Word in transmit order
    output reg [11:0] word_q
);

reg [11:0] pick;
reg [11:0] ordered;
reg [11:0] word_d;
integer i;

// Chooses the source word and then applies bit order and lane split.
always @* begin
    case (test_sel)
        `TEST_ZEROS: pick = `WORD_ZEROS;
        `TEST_ONES: pick = `WORD_ONES;
        `TEST_TOGGLE: pick = toggle_phase ? `WORD_TOGGLE_B : `WORD_TOGGLE_A;
        `TEST_USER: pick = user_word;
        `TEST_DESKEW: pick = `WORD_DESKEW;
        `TEST_SYNC: pick = `WORD_SYNC;
        default: pick = {sample[11] ^ straight_bin, sample[10:0]};
    endcase
    ordered = pick;
    for (i = 0; i < 12; i = i + 1) begin
        if (lsb_first) begin
            ordered[11 - i] = pick[i];
        end
    end
    word_d = ordered;
    if (two_lane && bit_wise) begin
        for (i = 0; i < 6; i = i + 1) begin
            word_d[11 - i] = ordered[11 - 2 * i];
            word_d[5 - i] = ordered[10 - 2 * i];
        end
    end
end

// Registers the word once per sample.
always @(posedge clk) begin
    if (!rst_n) begin
        word_q <= 12'h000;
    end else if (sample_valid) begin
        word_q <= word_d;
    end
end

endmodule // word_pattern_gen

// *** adc_output_config_registers.v ***
`timescale 1ns/100ps
`include "adc_cfg_defines.vh"

module adc_output_config_registers (
    // Clock and hardware reset
    input wire clk,
    input wire rst_n,
    // Serial control port
    input wire sen_n,
    input wire sclk,
    input wire sdata,
    // Parallel strap pins for the framing functions
    input wire strap_two_lane,
    input wire strap_sdr,
    input wire strap_14x,
    input wire strap_rise_edge,
    input wire strap_boost,
    input wire strap_lsb_first,
    input wire strap_bit_wise,
    // Conversion results, one sample per valid
    input wire sample_valid,
    input wire [11:0] conv_a,
    input wire [11:0] conv_b,
    input wire [11:0] conv_c,
    input wire [11:0] conv_d,
    // Analog settings
    output reg [4:0] clk_buf_code_q,
    output reg [2:0] clk_buf_step_q,
    output reg [2:0] step_gain_q,
    output reg boost_q,
    // Effective framing
    output reg two_lane_q,
    output reg sdr_clk_q,
    output reg ser_14x_q,
    output reg rise_capture_q,
    output reg launch_rising_q,
    output reg lsb_first_q,
    output reg bit_wise_q,
    // Transmit words in send order
    output wire [11:0] word_a_q,
    output wire [11:0] word_b_q,
    output wire [11:0] word_c_q,
    output wire [11:0] word_d_q,
    output reg word_valid_q
);

// ----------------------------------------------------------------
// Functions
// ----------------------------------------------------------------

// Maps a clock buffer gain code to its step, 0 lowest to 5 highest.
// Codes outside the table are taken as the default step.
function [2:0] clk_buf_step;
    input [4:0] code;
    begin
        case (code)
            `CLKBUF_MIN: clk_buf_step = 3'h0;
            `CLKBUF_DEF: clk_buf_step = 3'h1;
            `CLKBUF_G2: clk_buf_step = 3'h2;
            `CLKBUF_G3: clk_buf_step = 3'h3;
            `CLKBUF_G4: clk_buf_step = 3'h4;
            `CLKBUF_MAX: clk_buf_step = 3'h5;
            default: clk_buf_step = 3'h1;
        endcase
    end
endfunction

// Chooses a register framing bit or its strap pin.
// Used for every framing function so that all switch source together.
function pick_frame;
    input override;
    input reg_bit;
    input pin_bit;
    begin
        pick_frame = override ? reg_bit : pin_bit;
    end
endfunction

// ----------------------------------------------------------------
// Serial control port
// ----------------------------------------------------------------

// The receiver hands over one address and data pair per completed word.
// A word cut short by the enable rising is dropped there, never here.
wire [4:0] wr_addr;
wire [10:0] wr_data;
wire wr_strobe;

ser_word_receiver u_rx (
    .clk(clk),
    .rst_n(rst_n),
    .sen_n(sen_n),
    .sclk(sclk),
    .sdata(sdata),
    .addr_q(wr_addr),
    .data_q(wr_data),
    .strobe_q(wr_strobe)
);

// ----------------------------------------------------------------
// Configuration registers
// ----------------------------------------------------------------

// Only five addresses are mapped; a word to any other is ignored.
// Every register clears on either reset.
reg [10:0] coding_and_test_select_q;
reg [10:0] clock_input_buffer_level_q;
reg [10:0] user_word_low_bits_q;
reg [10:0] step_gain_and_user_top_bit_q;
reg [10:0] output_framing_control_q;
wire soft_reset;

// A write to the first register with the reset bit set clears all.
// The other bits of that word are dropped, as the clear covers them.
assign soft_reset = wr_strobe && (wr_addr == `ADDR_CODING_TEST)
    && wr_data[`SOFT_RESET_BIT];

// Whole-word writes; several fields of one register change at once.
// The reset bit is never stored, so it reads back as zero.
// Hardware reset and software reset share one clear path.
always @(posedge clk) begin
    if (!rst_n || soft_reset) begin
        coding_and_test_select_q <= `CFG_RESET;
        clock_input_buffer_level_q <= `CFG_RESET;
        user_word_low_bits_q <= `CFG_RESET;
        step_gain_and_user_top_bit_q <= `CFG_RESET;
        output_framing_control_q <= `CFG_RESET;
    end else if (wr_strobe) begin
        case (wr_addr)
            `ADDR_CODING_TEST: begin
                coding_and_test_select_q <= {1'b0, wr_data[9:0]};
            end
            `ADDR_CLK_BUF: begin
                clock_input_buffer_level_q <= wr_data;
            end
            `ADDR_USER_LOW: begin
                user_word_low_bits_q <= wr_data;
            end
            `ADDR_STEP_GAIN: begin
                step_gain_and_user_top_bit_q <= wr_data;
            end
            `ADDR_FRAMING: begin
                output_framing_control_q <= wr_data;
            end
            default: begin
                // Unmapped address: every register keeps its contents.
                coding_and_test_select_q <= coding_and_test_select_q;
            end
        endcase
    end
end

// ----------------------------------------------------------------
// Field decode
// ----------------------------------------------------------------

wire [2:0] test_sel;
wire straight_bin;
wire [11:0] user_word;
wire override;
wire [10:0] fr;

// Reserved code 100 is passed on; the builders send normal data for it.
// Test selection and coding, shared by all channels.
assign test_sel = coding_and_test_select_q[`TEST_HI:`TEST_LO];
assign straight_bin = coding_and_test_select_q[`CODING_BIT];

// The user word joins bit 0 of 0C, as its top bit, to the eleven bits of 0B.
assign user_word = {step_gain_and_user_top_bit_q[`USER_TOP_BIT],
    user_word_low_bits_q};

// Framing register and its override bit.
assign fr = output_framing_control_q;
assign override = fr[`FR_OVERRIDE];

// ----------------------------------------------------------------
// Effective settings
// ----------------------------------------------------------------

reg two_lane_d;
reg sdr_d;
reg rise_d;
reg x14_d;
reg boost_d;
reg lsb_first_d;
reg bit_wise_d;
reg [4:0] clk_buf_code_d;

// Framing follows the strap pins unless the override bit is set.
// Single-rate clock only exists with two lanes, and the capture
// edge only matters with a single-rate clock.
// All framing functions switch source together on the override bit.
always @* begin
    two_lane_d = pick_frame(override, fr[`FR_TWO_LANE], strap_two_lane);
    sdr_d = two_lane_d
        && pick_frame(override, fr[`FR_SDR], strap_sdr);
    rise_d = pick_frame(override, fr[`FR_RISE_EDGE], strap_rise_edge);
    x14_d = pick_frame(override, fr[`FR_14X], strap_14x);
    boost_d = pick_frame(override, fr[`FR_BOOST], strap_boost);
    lsb_first_d = pick_frame(override, fr[`FR_LSB_FIRST], strap_lsb_first);
    bit_wise_d = two_lane_d
        && pick_frame(override, fr[`FR_BIT_WISE], strap_bit_wise);
    clk_buf_code_d = clock_input_buffer_level_q[`CLKBUF_HI:`CLKBUF_LO];
end

// Registers every setting so each output leaves a flip-flop.
// Reset values match what the cleared registers decode to with all strap pins low.
always @(posedge clk) begin
    if (!rst_n) begin
        clk_buf_code_q <= `CLKBUF_DEF;
        clk_buf_step_q <= 3'h1;
        step_gain_q <= 3'h0;
        boost_q <= 1'b0;
        two_lane_q <= 1'b0;
        sdr_clk_q <= 1'b0;
        ser_14x_q <= 1'b0;
        rise_capture_q <= 1'b0;
        launch_rising_q <= 1'b0;
        lsb_first_q <= 1'b0;
        bit_wise_q <= 1'b0;
    end else begin
        clk_buf_code_q <= clk_buf_code_d;
        clk_buf_step_q <= clk_buf_step(clk_buf_code_d);
        step_gain_q <= step_gain_and_user_top_bit_q[`STEP_GAIN_HI:`STEP_GAIN_LO];
        boost_q <= boost_d;
        two_lane_q <= two_lane_d;
        sdr_clk_q <= sdr_d;
        ser_14x_q <= x14_d;
        rise_capture_q <= sdr_d && rise_d;
        // Data changes on the edge opposite the one the receiver uses.
        launch_rising_q <= sdr_d && !rise_d;
        lsb_first_q <= lsb_first_d;
        bit_wise_q <= bit_wise_d;
    end
end

// ----------------------------------------------------------------
// Toggle pattern phase and word valid
// ----------------------------------------------------------------

reg toggle_q;

// The toggle word alternates on each sample; valid follows sample.
// Only the hardware reset restarts the toggle; the software reset does not.
always @(posedge clk) begin
    if (!rst_n) begin
        toggle_q <= 1'b0;
        word_valid_q <= 1'b0;
    end else begin
        word_valid_q <= sample_valid;
        if (sample_valid) begin
            toggle_q <= ~toggle_q;
        end
    end
end

// ----------------------------------------------------------------
// Channel word builders
// ----------------------------------------------------------------

// One builder per channel, all fed the same settings.
// Sharing the settings keeps the four channels in step in every mode.
word_pattern_gen u_gen_a (
    .clk(clk),
    .rst_n(rst_n),
    .sample_valid(sample_valid),
    .sample(conv_a),
    .test_sel(test_sel),
    .straight_bin(straight_bin),
    .user_word(user_word),
    .toggle_phase(toggle_q),
    .lsb_first(lsb_first_q),
    .two_lane(two_lane_q),
    .bit_wise(bit_wise_q),
    .word_q(word_a_q)
);

// Channel B.
word_pattern_gen u_gen_b (
    .clk(clk),
    .rst_n(rst_n),
    .sample_valid(sample_valid),
    .sample(conv_b),
    .test_sel(test_sel),
    .straight_bin(straight_bin),
    .user_word(user_word),
    .toggle_phase(toggle_q),
    .lsb_first(lsb_first_q),
    .two_lane(two_lane_q),
    .bit_wise(bit_wise_q),
    .word_q(word_b_q)
);

// Channel C.
word_pattern_gen u_gen_c (
    .clk(clk),
    .rst_n(rst_n),
    .sample_valid(sample_valid),
    .sample(conv_c),
    .test_sel(test_sel),
    .straight_bin(straight_bin),
    .user_word(user_word),
    .toggle_phase(toggle_q),
    .lsb_first(lsb_first_q),
    .two_lane(two_lane_q),
    .bit_wise(bit_wise_q),
    .word_q(word_c_q)
);

// Channel D.
word_pattern_gen u_gen_d (
    .clk(clk),
    .rst_n(rst_n),
    .sample_valid(sample_valid),
    .sample(conv_d),
    .test_sel(test_sel),
    .straight_bin(straight_bin),
    .user_word(user_word),
    .toggle_phase(toggle_q),
    .lsb_first(lsb_first_q),
    .two_lane(two_lane_q),
    .bit_wise(bit_wise_q),
    .word_q(word_d_q)
);

endmodule // adc_output_config_registers

// *** adc_cfg_properties.sv ***
`timescale 1ns/100ps
// ------------------------------------------------------------
// Port checker for the configuration bank
// ------------------------------------------------------------
module adc_cfg_properties (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Watched ports
    input wire sample_valid,
    input wire [4:0] clk_buf_code_q,
    input wire [2:0] clk_buf_step_q,
    input wire two_lane_q,
    input wire sdr_clk_q,
    input wire rise_capture_q,
    input wire launch_rising_q,
    input wire bit_wise_q,
    input wire [11:0] word_a_q,
    input wire word_valid_q
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Gain step that each buffer code reports.
    function automatic [2:0] step_of(input [4:0] c);
        case (c)
            5'h18: step_of = 3'h0;
            5'h0c: step_of = 3'h2;
            5'h0a: step_of = 3'h3;
            5'h09: step_of = 3'h4;
            5'h08: step_of = 3'h5;
            default: step_of = 3'h1;
        endcase
    endfunction
    // A lone sample and the single pulse it gives.
    sequence s_lone_sample;
        sample_valid ##1 !sample_valid;
    endsequence
    sequence s_one_pulse;
        word_valid_q ##1 !word_valid_q;
    endsequence
    chk_valid_pulse: assert property (s_lone_sample |-> s_one_pulse)
        else $error("word valid pulse wrong");
    chk_no_stray_valid: assert property (!sample_valid |=> !word_valid_q)
        else $error("word valid without sample");
    chk_word_hold: assert property (!sample_valid |=> $stable(word_a_q))
        else $error("word changed without sample");
    chk_gain_step: assert property ($stable(clk_buf_code_q) |->
        clk_buf_step_q == step_of(clk_buf_code_q)) else $error("gain step wrong");
    chk_sdr_lanes: assert property (sdr_clk_q |-> two_lane_q)
        else $error("single rate in one lane");
    chk_split_lanes: assert property (bit_wise_q |-> two_lane_q)
        else $error("bit split in one lane");
    chk_capture_sdr: assert property (rise_capture_q |-> sdr_clk_q)
        else $error("capture edge without single rate");
    chk_launch_edge: assert property (launch_rising_q == (sdr_clk_q && !rise_capture_q))
        else $error("launch edge wrong");
    chk_reset_state: assert property ($rose(rst_n) |-> !two_lane_q && !word_valid_q
        && clk_buf_step_q == 3'h1 && clk_buf_code_q == 5'h00) else $error("reset state");
endmodule // adc_cfg_properties

// *** host_ser_model.sv ***
`timescale 1ns/100ps
// ------------------------------------------------------------
// Host controller on the serial control port
// ------------------------------------------------------------
module host_ser_model (
    // Clock
    input wire clk,
    // Serial control pins
    output reg sen_n,
    output reg sclk,
    output reg sdata
);
    integer i;
    // Idle: deselected, clock parked low.
    initial begin
        sen_n = 1'b1;
        sclk = 1'b0;
        sdata = 1'b0;
    end
    // Sends the first n bits of an address-first word; under 16 aborts it.
    task send(input [4:0] a, input [10:0] d, input integer n);
        reg [15:0] w;
        begin
            w = {a, d};
            @(negedge clk);
            sen_n = 1'b0;
            for (i = 15; i > 15 - n; i = i - 1) begin
                @(negedge clk);
                sdata = w[i];
                sclk = 1'b1;
                @(negedge clk);
                sclk = 1'b0;
            end
            @(negedge clk);
            sen_n = 1'b1;
            sdata = ~sdata; // The line is no longer driven with data.
        end
    endtask
endmodule // host_ser_model

// *** tb_top.sv ***
`timescale 1ns/100ps
`include "adc_cfg_defines.vh"
// ------------------------------------------------------------
// Bench for the configuration bank
// ------------------------------------------------------------
module tb_top;
    reg clk;
    reg rst_n;
    reg sample_valid;
    reg [6:0] strap;
    reg [3:0][11:0] cv;
    reg [11:0] uw;
    wire sen_n, sclk, sdata;
    wire [4:0] cb_code;
    wire [2:0] cb_step, sg;
    wire boost, two, sdr, x14, rise, launch, lsb, bitw, wv;
    wire [3:0][11:0] w;
    wire [11:0] fr = {4'h0, two, sdr, x14, rise, launch, boost, lsb, bitw};
    integer err_total, checks, k, nsmp;
    localparam [29:0] GC = {5'h08, 5'h09, 5'h0a, 5'h0c, 5'h00, 5'h18};
    // Clock at 25 MHz.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    host_ser_model host_ser_model_i (.clk(clk), .sen_n(sen_n), .sclk(sclk), .sdata(sdata));
    adc_output_config_registers adc_output_config_registers_i (
        .clk(clk), .rst_n(rst_n), .sen_n(sen_n), .sclk(sclk), .sdata(sdata),
        .strap_two_lane(strap[0]), .strap_sdr(strap[1]), .strap_14x(strap[2]),
        .strap_rise_edge(strap[3]), .strap_boost(strap[4]),
        .strap_lsb_first(strap[5]), .strap_bit_wise(strap[6]),
        .sample_valid(sample_valid), .conv_a(cv[0]), .conv_b(cv[1]),
        .conv_c(cv[2]), .conv_d(cv[3]), .clk_buf_code_q(cb_code),
        .clk_buf_step_q(cb_step), .step_gain_q(sg), .boost_q(boost),
        .two_lane_q(two), .sdr_clk_q(sdr), .ser_14x_q(x14), .rise_capture_q(rise),
        .launch_rising_q(launch), .lsb_first_q(lsb), .bit_wise_q(bitw),
        .word_a_q(w[0]), .word_b_q(w[1]), .word_c_q(w[2]), .word_d_q(w[3]),
        .word_valid_q(wv));
    // Compares one value and counts the result.
    task chk(input [11:0] seen, input [11:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task stop_test;
        begin
            $display("checks %0d errors %0d", checks, err_total);
            if (err_total == 0 && checks > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    // Writes one register and lets its outputs settle.
    task wr(input [4:0] a, input [10:0] d);
        begin
            host_ser_model_i.send(a, d, 16);
            repeat (3) @(negedge clk);
        end
    endtask
    // Sends one sample and checks all four words.
    task smp(input [2:0] t, input ob, input rev, input bw);
        reg [11:0] e;
        reg [11:0] f;
        integer j;
        integer m;
        begin
            @(negedge clk);
            sample_valid = 1'b1;
            @(negedge clk);
            sample_valid = 1'b0;
            chk({11'h000, wv}, 12'h001);
            for (j = 0; j < 4; j = j + 1) begin
                case (t)
                    `TEST_ZEROS: e = `WORD_ZEROS;
                    `TEST_ONES: e = `WORD_ONES;
                    `TEST_TOGGLE: e = nsmp[0] ? `WORD_TOGGLE_B : `WORD_TOGGLE_A;
                    `TEST_USER: e = uw;
                    `TEST_DESKEW: e = `WORD_DESKEW;
                    `TEST_SYNC: e = `WORD_SYNC;
                    default: e = cv[j] ^ {ob, 11'h000};
                endcase
                if (rev)
                    e = {<<{e}};
                // Even send positions go to the first lane, odd to the second.
                f = e;
                for (m = 0; m < 6; m = m + 1) begin
                    f[11 - m] = e[11 - 2 * m];
                    f[5 - m] = e[10 - 2 * m];
                end
                if (bw)
                    e = f;
                chk(w[j], e);
            end
            nsmp = nsmp + 1;
        end
    endtask
    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge clk);
        err_total = err_total + 1;
        stop_test;
    end
    // Main sequence.
    initial begin
        err_total = 0;
        checks = 0;
        nsmp = 0;
        rst_n = 1'b0;
        sample_valid = 1'b0;
        strap = 7'h00;
        cv = {12'h9bc, 12'h789, 12'h456, 12'h123};
        uw = 12'hda3;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        chk(fr, 12'h000);
        chk({9'h000, cb_step}, 12'h001);
        for (k = 0; k < 6; k = k + 1) begin
            wr(`ADDR_CLK_BUF, {4'h0, GC[k*5 +: 5], 2'h0});
            chk({7'h00, cb_code}, {7'h00, GC[k*5 +: 5]});
            chk({9'h000, cb_step}, k[11:0]);
        end
        wr(`ADDR_USER_LOW, 11'h5a3);
        wr(`ADDR_STEP_GAIN, 11'h601);
        chk({9'h000, sg}, 12'h006);
        for (k = 0; k < 8; k = k + 1) begin
            wr(`ADDR_CODING_TEST, {3'h0, k[2:0], 5'h00});
            smp(k[2:0], 1'b0, 1'b0, 1'b0);
            if (k == 3)
                smp(k[2:0], 1'b0, 1'b0, 1'b0);
        end
        wr(`ADDR_CODING_TEST, 11'h200);
        smp(`TEST_NORMAL, 1'b1, 1'b0, 1'b0);
        strap = 7'h7f;
        repeat (3) @(negedge clk);
        chk(fr, 12'h0f7);
        wr(`ADDR_FRAMING, 11'h400);
        chk(fr, 12'h000);
        wr(`ADDR_FRAMING, 11'h4b7);
        chk(fr, 12'h0f5);
        wr(`ADDR_FRAMING, 11'h403);
        chk(fr, 12'h0c8);
        wr(`ADDR_FRAMING, 11'h486);
        chk(fr, 12'h020);
        wr(`ADDR_FRAMING, 11'h440);
        chk(fr, 12'h002);
        smp(`TEST_NORMAL, 1'b1, 1'b1, 1'b0);
        wr(`ADDR_FRAMING, 11'h481);
        chk(fr, 12'h081);
        smp(`TEST_NORMAL, 1'b1, 1'b0, 1'b1);
        host_ser_model_i.send(`ADDR_CLK_BUF, 11'h060, 8);
        wr(5'h05, 11'h07f);
        chk({7'h00, cb_code}, 12'h008);
        strap = 7'h00;
        wr(`ADDR_CODING_TEST, 11'h400);
        chk({7'h00, cb_code}, 12'h000);
        chk({9'h000, sg}, 12'h000);
        chk(fr, 12'h000);
        uw = 12'h000;
        wr(`ADDR_CODING_TEST, 11'h0a0);
        smp(`TEST_USER, 1'b0, 1'b0, 1'b0);
        wr(`ADDR_CLK_BUF, 11'h060);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        chk({7'h00, cb_code}, 12'h000);
        chk({9'h000, cb_step}, 12'h001);
        stop_test;
    end
endmodule // tb_top

bind adc_output_config_registers adc_cfg_properties adc_cfg_properties_i (
    .clk(clk), .rst_n(rst_n), .sample_valid(sample_valid),
    .clk_buf_code_q(clk_buf_code_q), .clk_buf_step_q(clk_buf_step_q),
    .two_lane_q(two_lane_q), .sdr_clk_q(sdr_clk_q), .rise_capture_q(rise_capture_q),
    .launch_rising_q(launch_rising_q), .bit_wise_q(bit_wise_q),
    .word_a_q(word_a_q), .word_valid_q(word_valid_q));
